// File: csfd_pkg.sv
// Purpose: shared constants and types for the status flag and decode block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: flag byte order is c z s v d h u2 u1 from the top bit
package csfd_pkg;

    localparam int CSFD_AW = 12;
    localparam logic [CSFD_AW-1:0] CSFD_OFS_FLAGS = 12'h000;
    localparam logic [CSFD_AW-1:0] CSFD_OFS_DECODE = 12'h004;

    localparam int CSFD_BIT_C = 7;
    localparam int CSFD_BIT_Z = 6;
    localparam int CSFD_BIT_S = 5;
    localparam int CSFD_BIT_V = 4;
    localparam int CSFD_BIT_D = 3;
    localparam int CSFD_BIT_H = 2;
    localparam int CSFD_BIT_U2 = 1;
    localparam int CSFD_BIT_U1 = 0;

    // status bits (upper six) reset value; user bits have none
    localparam logic [5:0] CSFD_STATUS_RST = 6'h00;
    localparam logic [7:0] CSFD_ESCAPE_OP = 8'h1f;
    localparam int CSFD_DISP_W = 8;
    localparam int CSFD_ADDR_W = 16;

    typedef enum logic [3:0] {
        CSFD_CC_F, CSFD_CC_LT, CSFD_CC_LE, CSFD_CC_ULE,
        CSFD_CC_OV, CSFD_CC_MI, CSFD_CC_EQ, CSFD_CC_C,
        CSFD_CC_T, CSFD_CC_GE, CSFD_CC_GT, CSFD_CC_UGT,
        CSFD_CC_NOV, CSFD_CC_PL, CSFD_CC_NE, CSFD_CC_NC
    } csfd_cond_t;

    typedef enum logic [1:0] {
        CSFD_ENTRY_IRQ, CSFD_ENTRY_SWTRAP, CSFD_ENTRY_ILLEGAL
    } csfd_entry_t;

    // mask selects which of c z s v d h an operation writes
    typedef struct packed {
        logic [5:0] mask;
        logic [5:0] value;
    } csfd_upd_t;

    // explicit user flag command: mask bit1 = user two, bit0 = user one
    typedef struct packed {
        logic [1:0] mask;
        logic [1:0] value;
    } csfd_user_t;

    typedef struct packed {
        logic valid;
        logic second_map;
        logic [7:0] opcode;
    } csfd_dec_t;

endpackage

// File: csfd_sext.sv
// Purpose: registered sign extension of an index or displacement byte
// Assumes: input width below output width
// Notes: result held until the next valid input
`timescale 1ns/1ps
module csfd_sext #(
    parameter int IN_W = 8,
    parameter int OUT_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [IN_W-1:0] data_in,
    output logic valid_out,
    output logic [OUT_W-1:0] data_out
);
    logic [OUT_W-1:0] next_data;
    logic next_valid;

    always_comb begin
        next_valid = valid_in;
        next_data = data_out;
        if (valid_in) begin
            next_data = {{(OUT_W-IN_W){data_in[IN_W-1]}}, data_in};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            data_out <= '0;
        end else begin
            valid_out <= next_valid;
            data_out <= next_data;
        end
    end

    a_sext_sign: assert property (@(posedge clk_in) disable iff (rst_in) valid_in
        |=> data_out == {{(OUT_W-IN_W){$past(data_in[IN_W-1])}}, $past(data_in)})
        else $error("displacement not sign extended");
endmodule // csfd_sext

// File: csfd_top.sv
// Purpose: cpu status flag byte, jump condition test, opcode map select, apb view
// Assumes: cpu core drives one-cycle strobes synchronous to clk_in
// Notes: user flag bits have no reset and power up unknown
//
// Behaviour
// - six status bits follow the most recent alu, bit, rotate or shift result
// - carry, overflow, zero and sign feed conditional jump tests
// - half-carry and decimal bits are never jump conditions, bcd only
// - user bits survive alu operations; change only by explicit set or clear, apb flag write or interrupt return
// - user bits are never offered as jump conditions
// - user bits undefined at power-up and untouched by reset
// - interrupt, software trap and illegal trap push the flag byte
// - interrupt return reloads the flag byte from the stack value
// - index and displacement bytes are signed 8-bit values
`timescale 1ns/1ps
module csfd_top
    import csfd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [CSFD_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic upd_valid_in,
    input wire csfd_upd_t upd_in,
    input wire logic user_valid_in,
    input wire csfd_user_t user_in,
    input wire logic entry_valid_in,
    input wire csfd_entry_t entry_kind_in,
    input wire logic ret_valid_in,
    input wire logic [7:0] ret_flags_in,
    input wire logic cond_valid_in,
    input wire csfd_cond_t cond_in,
    input wire logic op_valid_in,
    input wire logic [7:0] op_in,
    input wire logic disp_valid_in,
    input wire logic [CSFD_DISP_W-1:0] disp_in,
    output logic [7:0] flags_out,
    output logic push_valid_out,
    output logic [7:0] push_data_out,
    output csfd_entry_t push_kind_out,
    output logic cond_done_out,
    output logic cond_true_out,
    output csfd_dec_t dec_out,
    output logic disp_valid_out,
    output logic [CSFD_ADDR_W-1:0] disp_out
);
    logic [5:0] status;
    logic [5:0] next_status;
    logic [1:0] user;
    logic [1:0] next_user;
    logic acc;
    logic apb_wr;
    logic wr_flags;
    logic [7:0] flag_byte;

    assign flag_byte = {status, user};
    assign acc = psel_in && penable_in && pready_out;
    assign apb_wr = acc && pwrite_in;
    assign wr_flags = apb_wr && (paddr_in == CSFD_OFS_FLAGS);

    // status bits; return beats a software write, which beats an alu update
    always_comb begin
        next_status = status;
        if (ret_valid_in) begin
            next_status = ret_flags_in[7:2];
        end else if (wr_flags) begin
            next_status = pwdata_in[7:2];
        end else if (upd_valid_in) begin
            next_status = (status & ~upd_in.mask) | (upd_in.value & upd_in.mask);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= CSFD_STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // user bits: alu updates never reach here
    always_comb begin
        next_user = user;
        if (ret_valid_in) begin
            next_user = ret_flags_in[1:0];
        end else if (wr_flags) begin
            next_user = pwdata_in[1:0];
        end else if (user_valid_in) begin
            next_user = (user & ~user_in.mask) | (user_in.value & user_in.mask);
        end
    end

    // no reset on purpose: reset must leave these bits alone
    always_ff @(posedge clk_in) begin
        user <= next_user;
    end

    // flag byte out and stack push
    logic [7:0] next_flags_q;
    logic next_push_valid;
    logic [7:0] next_push_data;
    csfd_entry_t next_push_kind;

    always_comb begin
        next_flags_q = {next_status, next_user};
        next_push_valid = entry_valid_in;
        next_push_data = push_data_out;
        next_push_kind = push_kind_out;
        if (entry_valid_in) begin
            next_push_data = flag_byte;
            next_push_kind = entry_kind_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            push_valid_out <= 1'b0;
            push_data_out <= 8'h00;
            push_kind_out <= CSFD_ENTRY_IRQ;
        end else begin
            push_valid_out <= next_push_valid;
            push_data_out <= next_push_data;
            push_kind_out <= next_push_kind;
        end
    end

    // mirror of the flag byte; user bits follow their own unreset flops
    always_ff @(posedge clk_in) begin
        flags_out <= next_flags_q;
    end

    // condition test uses only c v z s
    logic c_f;
    logic z_f;
    logic s_f;
    logic v_f;
    logic cond_hit;
    logic next_cond_done;
    logic next_cond_true;

    assign c_f = flag_byte[CSFD_BIT_C];
    assign z_f = flag_byte[CSFD_BIT_Z];
    assign s_f = flag_byte[CSFD_BIT_S];
    assign v_f = flag_byte[CSFD_BIT_V];

    always_comb begin
        case (cond_in)
            CSFD_CC_F: cond_hit = 1'b0;
            CSFD_CC_LT: cond_hit = s_f ^ v_f;
            CSFD_CC_LE: cond_hit = z_f | (s_f ^ v_f);
            CSFD_CC_ULE: cond_hit = c_f | z_f;
            CSFD_CC_OV: cond_hit = v_f;
            CSFD_CC_MI: cond_hit = s_f;
            CSFD_CC_EQ: cond_hit = z_f;
            CSFD_CC_C: cond_hit = c_f;
            CSFD_CC_T: cond_hit = 1'b1;
            CSFD_CC_GE: cond_hit = ~(s_f ^ v_f);
            CSFD_CC_GT: cond_hit = ~(z_f | (s_f ^ v_f));
            CSFD_CC_UGT: cond_hit = ~c_f & ~z_f;
            CSFD_CC_NOV: cond_hit = ~v_f;
            CSFD_CC_PL: cond_hit = ~s_f;
            CSFD_CC_NE: cond_hit = ~z_f;
            CSFD_CC_NC: cond_hit = ~c_f;
            default: cond_hit = 1'b0;
        endcase
        next_cond_done = cond_valid_in;
        next_cond_true = cond_true_out;
        if (cond_valid_in) begin
            next_cond_true = cond_hit;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cond_done_out <= 1'b0;
            cond_true_out <= 1'b0;
        end else begin
            cond_done_out <= next_cond_done;
            cond_true_out <= next_cond_true;
        end
    end

    // opcode map select
    typedef enum logic {CSFD_MAP_FIRST, CSFD_MAP_SECOND} csfd_map_state_t;
    csfd_map_state_t map_state;
    csfd_map_state_t next_map_state;
    csfd_dec_t next_dec;

    always_comb begin
        next_map_state = map_state;
        next_dec = dec_out;
        next_dec.valid = 1'b0;
        case (map_state)
            CSFD_MAP_FIRST: begin
                if (op_valid_in && op_in == CSFD_ESCAPE_OP) begin
                    next_map_state = CSFD_MAP_SECOND;
                end else if (op_valid_in) begin
                    next_dec = '{valid: 1'b1, second_map: 1'b0, opcode: op_in};
                end
            end
            CSFD_MAP_SECOND: begin
                if (op_valid_in) begin
                    next_dec = '{valid: 1'b1, second_map: 1'b1, opcode: op_in};
                    next_map_state = CSFD_MAP_FIRST;
                end
            end
            default: next_map_state = CSFD_MAP_FIRST;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            map_state <= CSFD_MAP_FIRST;
            dec_out <= '0;
        end else begin
            map_state <= next_map_state;
            dec_out <= next_dec;
        end
    end

    // signed displacement for indexed and relative forms
    csfd_sext #(.IN_W(CSFD_DISP_W), .OUT_W(CSFD_ADDR_W)) u_sext (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .valid_in(disp_valid_in),
        .data_in(disp_in),
        .valid_out(disp_valid_out),
        .data_out(disp_out)
    );

    // apb slave, one wait-free access phase
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup;
    logic mapped;

    assign setup = psel_in && !penable_in;
    assign mapped = (paddr_in == CSFD_OFS_FLAGS) || (paddr_in == CSFD_OFS_DECODE);

    always_comb begin
        next_pready = setup;
        next_pslverr = setup && !mapped;
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite_in) begin
            if (paddr_in == CSFD_OFS_FLAGS) begin
                next_prdata = {24'h00_0000, flag_byte};
            end else if (paddr_in == CSFD_OFS_DECODE) begin
                next_prdata = {22'h00_0000, (map_state == CSFD_MAP_SECOND), dec_out.second_map, dec_out.opcode};
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out <= next_prdata;
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // user bits power up unknown, so their check waits for a first full load
    logic user_known;
    logic next_user_known;

    always_comb begin
        next_user_known = user_known || ret_valid_in || wr_flags;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            user_known <= 1'b0;
        end else begin
            user_known <= next_user_known;
        end
    end

    sequence s_alu_only;
        upd_valid_in && !ret_valid_in && !wr_flags;
    endsequence

    sequence s_escape;
        map_state == CSFD_MAP_FIRST && op_valid_in && op_in == CSFD_ESCAPE_OP;
    endsequence

    sequence s_second_byte;
        map_state == CSFD_MAP_SECOND && op_valid_in;
    endsequence

    a_alu_status: assert property (s_alu_only |=>
        status == (($past(status) & ~$past(upd_in.mask)) | ($past(upd_in.value) & $past(upd_in.mask))))
        else $error("status bits not updated from result");
    a_user_keep: assert property (user_known && !user_valid_in && !ret_valid_in && !wr_flags
        |=> $stable(user))
        else $error("user bits changed without command");
    a_cond_carry: assert property (cond_valid_in && cond_in == CSFD_CC_C
        |=> cond_done_out && cond_true_out == $past(c_f))
        else $error("carry condition wrong");
    a_cond_no_hd: assert property (cond_valid_in && cond_in == CSFD_CC_LE
        |=> cond_true_out == ($past(z_f) | ($past(s_f) ^ $past(v_f))))
        else $error("less or equal condition wrong");
    a_cond_indep: assert property (cond_valid_in && cond_in == CSFD_CC_EQ |=> cond_true_out == $past(z_f))
        else $error("zero condition wrong");
    a_push_byte: assert property (entry_valid_in |=> push_valid_out && push_data_out == $past(flag_byte))
        else $error("pushed flag byte wrong");
    a_ret_reload: assert property (ret_valid_in
        |=> flag_byte == $past(ret_flags_in) && flags_out == $past(ret_flags_in))
        else $error("return did not reload flags");
    a_escape_enter: assert property (s_escape |=> map_state == CSFD_MAP_SECOND && !dec_out.valid)
        else $error("escape byte did not switch maps");
    a_escape_map: assert property (s_second_byte |=> dec_out.valid && dec_out.second_map)
        else $error("escape not followed by second map");
    a_order_carry: assert property (upd_valid_in && !ret_valid_in && !wr_flags && upd_in.mask[5]
        |=> flags_out[CSFD_BIT_C] == $past(upd_in.value[5]))
        else $error("flag byte order wrong");
endmodule // csfd_top

// File: csfd_top_tb.sv
// Purpose: self-checking bench for the status flag and decode block
// Assumes: core strobes last one cycle; apb master waits for pready
// Notes: user bits compared only after software has given them a value
`timescale 1ns/1ps
module csfd_top_tb;
    import csfd_pkg::*;
    logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
    logic [CSFD_AW-1:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, m, v;
    logic upd_valid_in, user_valid_in, entry_valid_in, ret_valid_in, cond_valid_in, op_valid_in, disp_valid_in;
    csfd_upd_t upd_in;
    csfd_user_t user_in;
    csfd_entry_t entry_kind_in, push_kind_out;
    csfd_cond_t cond_in;
    csfd_dec_t dec_out;
    logic [7:0] ret_flags_in, op_in, disp_in, flags_out, push_data_out, mf, f, d;
    logic push_valid_out, cond_done_out, cond_true_out, disp_valid_out;
    logic [CSFD_ADDR_W-1:0] disp_out;
    int miscompares, checks, i, k;

    csfd_top i_csfd_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .upd_valid_in(upd_valid_in), .upd_in(upd_in),
        .user_valid_in(user_valid_in), .user_in(user_in), .entry_valid_in(entry_valid_in),
        .entry_kind_in(entry_kind_in), .ret_valid_in(ret_valid_in), .ret_flags_in(ret_flags_in),
        .cond_valid_in(cond_valid_in), .cond_in(cond_in), .op_valid_in(op_valid_in), .op_in(op_in),
        .disp_valid_in(disp_valid_in), .disp_in(disp_in), .flags_out(flags_out),
        .push_valid_out(push_valid_out), .push_data_out(push_data_out), .push_kind_out(push_kind_out),
        .cond_done_out(cond_done_out), .cond_true_out(cond_true_out), .dec_out(dec_out),
        .disp_valid_out(disp_valid_out), .disp_out(disp_out));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // strobes are single cycle, so every driver ends here
    task automatic step;
        @(posedge clk_in);
        upd_valid_in <= 1'b0;
        user_valid_in <= 1'b0;
        entry_valid_in <= 1'b0;
        ret_valid_in <= 1'b0;
        cond_valid_in <= 1'b0;
        op_valid_in <= 1'b0;
        disp_valid_in <= 1'b0;
        #1;
    endtask

    // pready, read data and error all taken at the rising edge that ends the access
    task automatic apb(input logic w, input logic [CSFD_AW-1:0] a, input logic [31:0] dt);
        int n;
        logic ok;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= dt;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            ok = (pready_out === 1'b1);
            rd = prdata_out;
            err = pslverr_out;
            n++;
        end while (!ok && n < 16);
        chk(ok, 1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        #1;
    endtask

    task automatic dec_op(input logic [7:0] op);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_in <= op;
        step;
    endtask

    function automatic logic cond_exp(input logic [3:0] cc, input logic [7:0] fl);
        logic r;
        case (cc[2:0])
            3'd0: r = 1'b0;
            3'd1: r = fl[CSFD_BIT_S] ^ fl[CSFD_BIT_V];
            3'd2: r = fl[CSFD_BIT_Z] | (fl[CSFD_BIT_S] ^ fl[CSFD_BIT_V]);
            3'd3: r = fl[CSFD_BIT_C] | fl[CSFD_BIT_Z];
            3'd4: r = fl[CSFD_BIT_V];
            3'd5: r = fl[CSFD_BIT_S];
            3'd6: r = fl[CSFD_BIT_Z];
            default: r = fl[CSFD_BIT_C];
        endcase
        return r ^ cc[3];
    endfunction

    initial begin
        #800000;
        miscompares++;
        wrap_up;
    end

    initial begin
        {rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        rst_in = 1'b1;
        {upd_valid_in, user_valid_in, entry_valid_in, ret_valid_in, cond_valid_in, op_valid_in} = '0;
        {disp_valid_in, upd_in, user_in, ret_flags_in, op_in, disp_in} = '0;
        entry_kind_in = CSFD_ENTRY_IRQ;
        cond_in = CSFD_CC_F;
        void'($urandom(32'h7e6f));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk(flags_out[7:2], CSFD_STATUS_RST);
        chk(pready_out, 0);
        apb(1'b1, CSFD_OFS_FLAGS, 32'h0000_00a5);
        mf = 8'ha5;
        apb(1'b0, CSFD_OFS_FLAGS, 32'h0);
        chk(rd, {24'h0, mf});
        chk(flags_out, mf);
        apb(1'b1, 12'h010, 32'h0000_00ff);
        chk(err, 1);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1);
        chk(rd, 32'h0);
        apb(1'b0, CSFD_OFS_FLAGS, 32'h0);
        chk(rd, {24'h0, mf});
        $display("apb test done");
        for (i = 0; i < 60; i++) begin
            m = $urandom;
            v = $urandom;
            k = $urandom % 3;
            @(posedge clk_in);
            if (k == 0) begin
                upd_valid_in <= 1'b1;
                upd_in <= {m[5:0], v[5:0]};
                mf[7:2] = (mf[7:2] & ~m[5:0]) | (v[5:0] & m[5:0]);
            end else if (k == 1) begin
                user_valid_in <= 1'b1;
                user_in <= {m[1:0], v[1:0]};
                mf[1:0] = (mf[1:0] & ~m[1:0]) | (v[1:0] & m[1:0]);
            end else begin
                ret_valid_in <= 1'b1;
                ret_flags_in <= v[7:0];
                mf = v[7:0];
            end
            step;
            @(posedge clk_in);
            #1;
            chk(flags_out, mf);
        end
        $display("flag traffic test done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk_in);
            entry_valid_in <= 1'b1;
            entry_kind_in <= csfd_entry_t'(k);
            step;
            chk({push_valid_out, push_data_out, push_kind_out}, {1'b1, mf, k[1:0]});
        end
        for (i = 0; i < 48; i++) begin
            f = $urandom;
            @(posedge clk_in);
            ret_valid_in <= 1'b1;
            ret_flags_in <= f;
            step;
            @(posedge clk_in);
            cond_valid_in <= 1'b1;
            cond_in <= csfd_cond_t'(i % 16);
            step;
            chk({cond_done_out, cond_true_out}, {1'b1, cond_exp(4'(i % 16), f)});
        end
        mf = f;
        $display("entry and condition test done");
        dec_op(8'h3c);
        chk(dec_out, {1'b1, 1'b0, 8'h3c});
        dec_op(CSFD_ESCAPE_OP);
        chk(dec_out.valid, 0);
        apb(1'b0, CSFD_OFS_DECODE, 32'h0);
        chk(rd[9], 1);
        dec_op(8'h55);
        chk(dec_out, {1'b1, 1'b1, 8'h55});
        apb(1'b0, CSFD_OFS_DECODE, 32'h0);
        chk(rd, {22'h0, 1'b0, 1'b1, 8'h55});
        dec_op(CSFD_ESCAPE_OP);
        dec_op(CSFD_ESCAPE_OP);
        chk(dec_out, {1'b1, 1'b1, CSFD_ESCAPE_OP});
        $display("decode test done");
        for (i = 0; i < 20; i++) begin
            d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
            @(posedge clk_in);
            disp_valid_in <= 1'b1;
            disp_in <= d;
            step;
            chk({disp_valid_out, disp_out}, {1'b1, {8{d[7]}}, d});
        end
        $display("displacement test done");
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk(flags_out, {CSFD_STATUS_RST, mf[1:0]});
        $display("reset test done");
        wrap_up;
    end
endmodule // csfd_top_tb
